// *** hdl/qcfg_pkg.sv ***
/*
 * Constants of the common configuration register bank: register byte
 * offsets, ring counts, offered feature set, status bit positions, and
 * the reset timings of the device and of a single ring.
 * Assumes a 20 MHz register clock.
 */
package qcfg_pkg;

    // timing
    localparam int CLK_PERIOD_NS      = 50;
    localparam int DEV_RESET_NS       = 200;
    localparam int DEV_RESET_CYCLES   = (DEV_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RING_RESET_NS      = 400;
    localparam int RING_RESET_CYCLES  = (RING_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W              = 4;

    // rings: ordinary ones first, management ones directly above them
    localparam int RING_COUNT         = 2;
    localparam int MGMT_RING_COUNT    = 1;
    localparam int ALL_RINGS          = RING_COUNT + MGMT_RING_COUNT;
    localparam int RING_IX_W          = 2;
    localparam int ADDR_WORDS         = 6;
    localparam logic [15:0] MAX_QUEUE_COUNT  = 16'h0002;
    localparam logic [15:0] MGMT_FIRST       = 16'h0002;
    localparam logic [15:0] MGMT_COUNT       = 16'h0001;
    localparam logic [15:0] ALL_RINGS_W      = 16'h0003;
    localparam logic [15:0] MAX_RING_ENTRIES = 16'h0100;

    // register byte offsets within the structure
    localparam logic [5:0] OFS_OFFER_PAGE  = 6'h00;
    localparam logic [5:0] OFS_OFFER_WORD  = 6'h04;
    localparam logic [5:0] OFS_ACCEPT_PAGE = 6'h08;
    localparam logic [5:0] OFS_ACCEPT_WORD = 6'h0C;
    localparam logic [5:0] OFS_CFG_VEC     = 6'h10;
    localparam logic [5:0] OFS_STATUS      = 6'h14;
    localparam logic [5:0] OFS_RING_SIZE   = 6'h18;
    localparam logic [5:0] OFS_RING_RUN    = 6'h1C;
    localparam logic [5:0] OFS_ADDR_FIRST  = 6'h20;
    localparam logic [5:0] OFS_TAG_RESET   = 6'h38;
    localparam logic [5:0] OFS_MGMT        = 6'h3C;

    // feature bit positions
    localparam int FEAT_VERSION_1     = 32;
    localparam int FEAT_RING_PACKED   = 34;
    localparam int FEAT_DOORBELL_TAG  = 39;
    localparam int FEAT_RING_RESET    = 40;
    localparam int MGMT_RING_FEATURE  = 41;
    localparam logic [63:0] OFFERED_FEATURES = (64'h1 << FEAT_VERSION_1)
                                             | (64'h1 << FEAT_DOORBELL_TAG)
                                             | (64'h1 << FEAT_RING_RESET)
                                             | (64'h1 << MGMT_RING_FEATURE);
    localparam int FEATURES_ACCEPTED_BIT = 3;

    // locating capability of this structure
    localparam logic [31:0] COMMON_CFG_OFFSET = 32'h0000_0000;
    localparam logic [7:0]  CAP_BODY_LEN      = 8'h10;
    localparam logic [7:0]  CAP_LEN           = 8'h10;

endpackage

// *** hdl/queue_feature_config_bank.sv ***
/*
 * Common configuration register bank: feature offer and acceptance,
 * initialization state with timed device reset, configuration change
 * counter and per-ring fields behind a ring pointer.
 * Assumes a simple synchronous register port with byte enables on a
 * 32-bit word; read data follows one cycle after the read strobe.
 */
// Overview of operation
// RULE1: offered word shows page*32 bits, else zero
// RULE2: page 0 is bits 0-31, 1 is 32-63
// RULE3: accepted word keeps only offered written bits
// RULE4: max count excludes management rings
// RULE5: writing zero resets; zero read after completion
// RULE6: counter changes after reading changed configuration
// RULE7: changed flag drives counter bump on read
// RULE8: ring pointer picks per-ring field copy
// RULE9: entry count resets to maximum; zero if absent
// RULE10: without packed rings count is power of two
// RULE11: ring serviced only while run flag is one
// RULE12: device reset clears every run flag
// RULE13: ring reset reads zero after reset, enable
// RULE14: ring reset busy reads one, then clears both
// RULE15: doorbell slot index is read-only unit index
// RULE16: driver writes three area addresses per ring
// RULE17: doorbell tag valid only when feature negotiated
// RULE18: management rings span first to first+count-1
// RULE19: management range sits above, fits 16 bits
// RULE20: structure offset is four-byte aligned
// RULE21: capability length covers all extra data
// RULE22: multiple capabilities listed best first
// RULE23: configuration and per-ring event vectors held
// RULE24: little-endian, 64-bit halves independent
// RULE25: driver uses natural aligned access widths
// RULE26: driver never writes zero to run flag
// RULE27: nonzero state stored; read-only writes ignored
`timescale 1ns/1ns
module queue_feature_config_bank
(
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic [5:0]                      acc_addr,
    input  wire logic                            acc_wr,
    input  wire logic                            acc_rd,
    input  wire logic [3:0]                      acc_be,
    input  wire logic [31:0]                     acc_wdata,
    output logic      [31:0]                     acc_rdata,
    output logic                                 acc_rvalid,
    input  wire logic                            devcfg_changed,
    input  wire logic                            devcfg_read,
    output logic      [qcfg_pkg::ALL_RINGS-1:0]  ring_run,
    output logic                                 dev_reset_busy,
    output logic                                 features_locked
);
    import qcfg_pkg::*;

    function automatic logic word_hit(input logic [5:0] a, input logic [5:0] ofs);
        word_hit = (a[5:2] == ofs[5:2]);
    endfunction

    function automatic logic pow2_or_zero(input logic [15:0] v);
        pow2_or_zero = ((v & (v - 16'h0001)) == 16'h0000);
    endfunction

    logic [31:0]           offer_page_r;
    logic [31:0]           accept_page_r;
    logic [63:0]           accept_feat_r;
    logic [15:0]           cfg_vec_r;
    logic [7:0]            status_r;
    logic [7:0]            gen_r;
    logic                  chg_flag_r;
    logic [15:0]           sel_r;
    logic                  devrst_busy_r;
    logic [CNT_W-1:0]      devrst_cnt_r;
    logic                  qrst_busy_r;
    logic [CNT_W-1:0]      qrst_cnt_r;
    logic [RING_IX_W-1:0]  qrst_idx_r;
    logic [15:0]           q_size_r [ALL_RINGS];
    logic [15:0]           q_vec_r  [ALL_RINGS];
    logic                  q_en_r   [ALL_RINGS];
    logic                  q_rst_r  [ALL_RINGS];
    logic [31:0]           q_addr_r [ALL_RINGS][ADDR_WORDS];
    logic [31:0]           rd_word;
    logic [31:0]           rdata_r;
    logic                  rvalid_r;

    // byte-lane qualified write strobes; fields are only written whole
    wire wr_word = acc_wr && (acc_be == 4'hF);
    wire wr_lo16 = acc_wr && (acc_be[1:0] == 2'b11);
    wire wr_hi16 = acc_wr && (acc_be[3:2] == 2'b11);
    wire wr_b0   = acc_wr && acc_be[0];

    wire [63:0] negotiated = accept_feat_r;
    wire packed_neg   = negotiated[FEAT_RING_PACKED];
    wire tag_neg      = negotiated[FEAT_DOORBELL_TAG];
    wire rrst_neg     = negotiated[FEAT_RING_RESET];
    wire mgmt_neg     = negotiated[MGMT_RING_FEATURE];

    // management rings exist only once their feature is negotiated
    wire sel_avail = (sel_r < MAX_QUEUE_COUNT)
                  || (mgmt_neg && (sel_r >= MGMT_FIRST) && (sel_r < ALL_RINGS_W)); // [RULE18]
    wire [RING_IX_W-1:0] sel_ix = sel_r[RING_IX_W-1:0];

    wire hit_addr = (acc_addr[5:2] >= OFS_ADDR_FIRST[5:2])
                 && (acc_addr[5:2] < (OFS_ADDR_FIRST[5:2] + 4'(ADDR_WORDS)));
    wire [3:0] addr_slot = acc_addr[5:2] - OFS_ADDR_FIRST[5:2];

    wire dev_start  = wr_b0 && word_hit(acc_addr, OFS_STATUS)
                   && (acc_wdata[7:0] == 8'h00) && !devrst_busy_r; // [RULE5]
    wire dev_done   = devrst_busy_r && (devrst_cnt_r == '0);
    wire stat_store = wr_b0 && word_hit(acc_addr, OFS_STATUS)
                   && (acc_wdata[7:0] != 8'h00) && !devrst_busy_r; // [RULE27]

    wire qrst_start = wr_hi16 && word_hit(acc_addr, OFS_TAG_RESET) && acc_wdata[16]
                   && rrst_neg && sel_avail && !qrst_busy_r && !devrst_busy_r; // [RULE14]
    wire qrst_done  = qrst_busy_r && (qrst_cnt_r == '0);

    wire cfg_bump   = devcfg_read && chg_flag_r; // [RULE7]

    wire [31:0] offer_word = (offer_page_r == 32'h0) ? OFFERED_FEATURES[31:0]
                           : (offer_page_r == 32'h1) ? OFFERED_FEATURES[63:32]
                           : 32'h0000_0000; // [RULE1] [RULE2]
    wire [31:0] accept_word = (accept_page_r == 32'h0) ? accept_feat_r[31:0]
                            : (accept_page_r == 32'h1) ? accept_feat_r[63:32]
                            : 32'h0000_0000;
    wire accept_wr = wr_word && word_hit(acc_addr, OFS_ACCEPT_WORD) && !devrst_busy_r;

    // global registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            offer_page_r  <= 32'h0000_0000;
            accept_page_r <= 32'h0000_0000;
            cfg_vec_r     <= 16'h0000;
            sel_r         <= 16'h0000;
        end else if (devrst_busy_r) begin
            offer_page_r  <= 32'h0000_0000;
            accept_page_r <= 32'h0000_0000;
            cfg_vec_r     <= 16'h0000;
            sel_r         <= 16'h0000;
        end else begin
            if (wr_word && word_hit(acc_addr, OFS_OFFER_PAGE))
                offer_page_r <= acc_wdata;
            if (wr_word && word_hit(acc_addr, OFS_ACCEPT_PAGE))
                accept_page_r <= acc_wdata;
            if (wr_lo16 && word_hit(acc_addr, OFS_CFG_VEC))
                cfg_vec_r <= acc_wdata[15:0]; // [RULE23]
            if (wr_hi16 && word_hit(acc_addr, OFS_STATUS))
                sel_r <= acc_wdata[31:16]; // [RULE8]
        end
    end

    // unoffered bits are dropped on write so negotiation needs no later check
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            accept_feat_r <= 64'h0;
        end else if (devrst_busy_r) begin
            accept_feat_r <= 64'h0;
        end else if (accept_wr && (accept_page_r == 32'h0)) begin
            accept_feat_r[31:0] <= acc_wdata & OFFERED_FEATURES[31:0]; // [RULE3]
        end else if (accept_wr && (accept_page_r == 32'h1)) begin
            accept_feat_r[63:32] <= acc_wdata & OFFERED_FEATURES[63:32]; // [RULE3]
        end
    end

    // status keeps its old value until the timed reset has run out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_r      <= 8'h00;
            devrst_busy_r <= 1'b0;
            devrst_cnt_r  <= '0;
        end else if (dev_start) begin
            devrst_busy_r <= 1'b1;
            devrst_cnt_r  <= CNT_W'(DEV_RESET_CYCLES - 1);
        end else if (dev_done) begin
            devrst_busy_r <= 1'b0;
            status_r      <= 8'h00; // [RULE5]
        end else if (devrst_busy_r) begin
            devrst_cnt_r  <= devrst_cnt_r - 1'b1;
        end else if (stat_store) begin
            status_r      <= acc_wdata[7:0]; // [RULE27]
        end
    end

    // a change arriving with the bumping read keeps the flag set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            chg_flag_r <= 1'b0;
            gen_r      <= 8'h00;
        end else begin
            chg_flag_r <= devcfg_changed || (chg_flag_r && !cfg_bump); // [RULE7]
            if (cfg_bump)
                gen_r <= gen_r + 8'h01; // [RULE6]
        end
    end

    // one ring reset at a time; a second request while the first runs is ignored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            qrst_busy_r <= 1'b0;
            qrst_cnt_r  <= '0;
            qrst_idx_r  <= '0;
        end else if (devrst_busy_r) begin
            qrst_busy_r <= 1'b0;
        end else if (qrst_start) begin
            qrst_busy_r <= 1'b1;
            qrst_cnt_r  <= CNT_W'(RING_RESET_CYCLES - 1);
            qrst_idx_r  <= sel_ix;
        end else if (qrst_done) begin
            qrst_busy_r <= 1'b0;
        end else if (qrst_busy_r) begin
            qrst_cnt_r  <= qrst_cnt_r - 1'b1;
        end
    end

    // per-ring field copies
    genvar gi;
    generate
        for (gi = 0; gi < ALL_RINGS; gi++) begin : g_ring
            wire hit      = sel_avail && (sel_ix == RING_IX_W'(gi)) && !devrst_busy_r; // [RULE8]
            wire clr      = devrst_busy_r || (qrst_done && (qrst_idx_r == RING_IX_W'(gi)));
            wire size_ok  = (acc_wdata[15:0] <= MAX_RING_ENTRIES)
                         && (packed_neg ? (acc_wdata[15:0] != 16'h0000)
                                        : pow2_or_zero(acc_wdata[15:0])); // [RULE10]
            wire size_wr  = hit && wr_lo16 && word_hit(acc_addr, OFS_RING_SIZE) && size_ok;
            wire vec_wr   = hit && wr_hi16 && word_hit(acc_addr, OFS_RING_SIZE);
            // zero writes to the run flag are ignored, enabling during reset too
            wire run_wr   = hit && wr_lo16 && word_hit(acc_addr, OFS_RING_RUN)
                         && (acc_wdata[15:0] == 16'h0001) && !q_rst_r[gi]; // [RULE26]

            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    q_size_r[gi] <= MAX_RING_ENTRIES;
                    q_vec_r[gi]  <= 16'h0000;
                    q_en_r[gi]   <= 1'b0;
                    q_rst_r[gi]  <= 1'b0;
                end else if (clr) begin
                    q_size_r[gi] <= MAX_RING_ENTRIES; // [RULE9]
                    q_vec_r[gi]  <= 16'h0000;
                    q_en_r[gi]   <= 1'b0; // [RULE12] [RULE14]
                    q_rst_r[gi]  <= 1'b0; // [RULE13] [RULE14]
                end else begin
                    if (size_wr)
                        q_size_r[gi] <= acc_wdata[15:0]; // [RULE9]
                    if (vec_wr)
                        q_vec_r[gi] <= acc_wdata[31:16]; // [RULE23]
                    if (run_wr)
                        q_en_r[gi] <= 1'b1; // [RULE11]
                    if (qrst_start && (sel_ix == RING_IX_W'(gi)))
                        q_rst_r[gi] <= 1'b1; // [RULE14]
                end
            end

            // each 32-bit half of the three 64-bit addresses stands alone
            for (genvar gw = 0; gw < ADDR_WORDS; gw++) begin : g_addr
                always_ff @(posedge clock or posedge rst) begin
                    if (rst)
                        q_addr_r[gi][gw] <= 32'h0000_0000;
                    else if (clr)
                        q_addr_r[gi][gw] <= 32'h0000_0000;
                    else if (hit && wr_word && hit_addr && (addr_slot == 4'(gw)))
                        q_addr_r[gi][gw] <= acc_wdata; // [RULE16] [RULE24]
                end
            end

            assign ring_run[gi] = q_en_r[gi]; // [RULE11]

            AST_SIZE_POW2: assert property (@(posedge clock) disable iff (rst) // [RULE10]
                !packed_neg |-> pow2_or_zero(q_size_r[gi]))
                else $error("ring entry count not a power of two");
            AST_ENABLE_CLEARS_RST: assert property (@(posedge clock) disable iff (rst) // [RULE13]
                $rose(q_en_r[gi]) |-> !q_rst_r[gi])
                else $error("ring reset flag set while ring enabled");
        end
    endgenerate

    // read selection; absent rings and unnegotiated fields read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (acc_addr[5:2])
            OFS_OFFER_PAGE[5:2]:  rd_word = offer_page_r;
            OFS_OFFER_WORD[5:2]:  rd_word = offer_word;
            OFS_ACCEPT_PAGE[5:2]: rd_word = accept_page_r;
            OFS_ACCEPT_WORD[5:2]: rd_word = accept_word;
            OFS_CFG_VEC[5:2]:     rd_word = {MAX_QUEUE_COUNT, cfg_vec_r}; // [RULE4]
            OFS_STATUS[5:2]:      rd_word = {sel_r, gen_r, status_r};
            OFS_RING_SIZE[5:2]:   rd_word = sel_avail ? {q_vec_r[sel_ix], q_size_r[sel_ix]}
                                                      : 32'h0000_0000; // [RULE9]
            // doorbell slot index equals the ring number, read-only
            OFS_RING_RUN[5:2]:    rd_word = sel_avail ? {sel_r, 15'h0000, q_en_r[sel_ix]}
                                                      : 32'h0000_0000; // [RULE15]
            OFS_TAG_RESET[5:2]:   rd_word = sel_avail ? {15'h0000, q_rst_r[sel_ix] && rrst_neg,
                                                         tag_neg ? sel_r : 16'h0000}
                                                      : 32'h0000_0000; // [RULE17]
            OFS_MGMT[5:2]:        rd_word = mgmt_neg ? {MGMT_COUNT, MGMT_FIRST}
                                                     : 32'h0000_0000; // [RULE18]
            default: begin
                if (hit_addr && sel_avail)
                    rd_word = q_addr_r[sel_ix][addr_slot[2:0]]; // [RULE24]
            end
        endcase
    end

    // reads have no side effects on this structure
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r  <= 32'h0000_0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= acc_rd;
            if (acc_rd)
                rdata_r <= rd_word;
        end
    end

    assign acc_rdata       = rdata_r;
    assign acc_rvalid      = rvalid_r;
    assign dev_reset_busy  = devrst_busy_r;
    assign features_locked = status_r[FEATURES_ACCEPTED_BIT];

    AST_OFFER_HIGH_PAGE: assert property (@(posedge clock) disable iff (rst) // [RULE1]
        (acc_rd && word_hit(acc_addr, OFS_OFFER_WORD) && (offer_page_r > 32'h1))
        |=> (acc_rdata == 32'h0000_0000))
        else $error("offered word nonzero for high page");
    AST_OFFER_PAGE_ONE: assert property (@(posedge clock) disable iff (rst) // [RULE2]
        (acc_rd && word_hit(acc_addr, OFS_OFFER_WORD) && (offer_page_r == 32'h1))
        |=> (acc_rdata == OFFERED_FEATURES[63:32]))
        else $error("offered page one shows wrong bits");
    AST_ACCEPT_SUBSET: assert property (@(posedge clock) disable iff (rst) // [RULE3]
        (accept_feat_r & ~OFFERED_FEATURES) == 64'h0)
        else $error("accepted feature not offered");
    AST_DEV_RESET_LEN: assert property (@(posedge clock) disable iff (rst) // [RULE5]
        dev_start |=> devrst_busy_r [*4] ##1 (!devrst_busy_r && status_r == 8'h00))
        else $error("device reset length or final status wrong");
    AST_GEN_CHANGES: assert property (@(posedge clock) disable iff (rst) // [RULE6]
        (devcfg_read && chg_flag_r) |=> (gen_r != $past(gen_r)))
        else $error("change counter did not move");
    AST_FLAG_SET_WINS: assert property (@(posedge clock) disable iff (rst) // [RULE7]
        devcfg_changed |=> chg_flag_r)
        else $error("changed flag lost");
    AST_RUN_CLEARED: assert property (@(posedge clock) disable iff (rst) // [RULE12]
        devrst_busy_r |=> (ring_run == '0))
        else $error("run flag survives device reset");
    AST_RING_RESET_LEN: assert property (@(posedge clock) disable iff (rst) // [RULE14]
        (qrst_start && !devrst_busy_r) |=> q_rst_r[qrst_idx_r] [*8]
        ##1 (!q_rst_r[qrst_idx_r] && !q_en_r[qrst_idx_r]))
        else $error("ring reset length or final flags wrong");
    AST_MGMT_RANGE: assert property (@(posedge clock) disable iff (rst) // [RULE19]
        (MGMT_FIRST >= MAX_QUEUE_COUNT) && ({1'b0, MGMT_COUNT} <= (17'h10000 - {1'b0, MGMT_FIRST})))
        else $error("management range out of bounds");
    // the only locating capability; a second copy would be listed after it
    AST_CAP_LAYOUT: assert property (@(posedge clock) disable iff (rst) // [RULE20] [RULE21] [RULE22]
        (COMMON_CFG_OFFSET[1:0] == 2'b00) && (CAP_LEN >= CAP_BODY_LEN))
        else $error("capability offset or length wrong");

    AST_ABSENT_SIZE_ZERO: assert property (@(posedge clock) disable iff (rst) // [RULE9]
        (acc_rd && word_hit(acc_addr, OFS_RING_SIZE) && !sel_avail)
        |=> (acc_rdata == 32'h0000_0000))
        else $error("absent ring size not zero");

    AST_MAX_COUNT_FIXED: assert property (@(posedge clock) disable iff (rst) // [RULE4]
        (acc_rd && word_hit(acc_addr, OFS_CFG_VEC))
        |=> (acc_rdata[31:16] == MAX_QUEUE_COUNT))
        else $error("maximum ring count wrong");

    // nonzero writes only; a zero write starts the reset instead
    AST_STATUS_STORED: assert property (@(posedge clock) disable iff (rst) // [RULE27]
        stat_store
        |=> ({24'h000000, status_r} == ($past(acc_wdata) & 32'h0000_00FF)))
        else $error("status byte not stored");

endmodule

// *** sim/host_driver_model.sv ***
/*
 * Driver-side model of the register port: one write or read per call.
 * Assumes the bank's register port contract, with the read answer one
 * cycle after the read strobe.
 */
`timescale 1ns/1ns
module host_driver_model (
    input  wire logic        clock,
    output logic      [5:0]  acc_addr,
    output logic             acc_wr,
    output logic             acc_rd,
    output logic      [3:0]  acc_be,
    output logic      [31:0] acc_wdata,
    input  wire logic [31:0] acc_rdata,
    input  wire logic        acc_rvalid
);
    initial begin
        acc_addr  = 6'h00;
        acc_wr    = 1'b0;
        acc_rd    = 1'b0;
        acc_be    = 4'h0;
        acc_wdata = 32'h0000_0000;
    end

    // word-aligned address, lanes that cover whole fields only
    task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        acc_addr  <= {a[5:2], 2'b00};
        acc_be    <= be;
        acc_wdata <= d;
        acc_wr    <= 1'b1;
        @(posedge clock);
        acc_wr    <= 1'b0;
        // released lines are scrambled so a stale value never looks valid
        acc_addr  <= ~a;
        acc_wdata <= ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic v);
        @(posedge clock);
        acc_addr <= {a[5:2], 2'b00};
        acc_be   <= 4'hF;
        acc_rd   <= 1'b1;
        @(posedge clock);
        acc_rd   <= 1'b0;
        acc_addr <= ~a;
        #1;
        v = acc_rvalid;
        d = acc_rdata;
    endtask
endmodule

// *** sim/test_queue_feature_config_bank.sv ***
/*
 * Self-checking bench of the common configuration register bank.
 * Assumes the package constants and the host driver model's port tasks.
 */
`timescale 1ns/1ns
module test_queue_feature_config_bank;
    import qcfg_pkg::*;
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    logic [5:0]           acc_addr;
    logic                 acc_wr;
    logic                 acc_rd;
    logic [3:0]           acc_be;
    logic [31:0]          acc_wdata;
    logic [31:0]          acc_rdata;
    logic                 acc_rvalid;
    logic                 devcfg_changed = 1'b0;
    logic                 devcfg_read = 1'b0;
    logic [ALL_RINGS-1:0] ring_run;
    logic                 dev_reset_busy;
    logic                 features_locked;
    int                   n_errors = 0;
    int                   num_checks = 0;
    int                   cycles = 0;

    always #25 clock = ~clock;

    queue_feature_config_bank u_queue_feature_config_bank (.clock(clock), .rst(rst),
        .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_be(acc_be),
        .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
        .devcfg_changed(devcfg_changed), .devcfg_read(devcfg_read), .ring_run(ring_run),
        .dev_reset_busy(dev_reset_busy), .features_locked(features_locked));

    host_driver_model u_host_driver_model (.clock(clock), .acc_addr(acc_addr),
        .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_be(acc_be), .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        u_host_driver_model.rd(a, d, v);
        chk_pin({2'b00, v}, 3'b001);
        chk_reg(d, exp);
    endtask

    // status lane left disabled so only the ring pointer changes
    task automatic sel(input int n);
        u_host_driver_model.wr(OFS_STATUS, 4'hC, {n[15:0], 16'h0000});
    endtask

    task automatic devcfg_pulse(input logic chg);
        @(posedge clock);
        devcfg_changed <= chg;
        @(posedge clock);
        devcfg_read    <= 1'b1;
        @(posedge clock);
        devcfg_changed <= 1'b0;
        devcfg_read    <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rchk(OFS_RING_SIZE, {16'h0000, MAX_RING_ENTRIES});
        rchk(OFS_RING_RUN, 32'h0000_0000);
        u_host_driver_model.wr(OFS_CFG_VEC, 4'h3, 32'h0000_0005);
        rchk(OFS_CFG_VEC, {MAX_QUEUE_COUNT, 16'h0005});
        $display("test reset values done");
        for (int p = 0; p < 3; p++) begin
            u_host_driver_model.wr(OFS_OFFER_PAGE, 4'hF, 32'(p));
            rchk(OFS_OFFER_WORD, p == 0 ? OFFERED_FEATURES[31:0] :
                 p == 1 ? OFFERED_FEATURES[63:32] : 32'h0000_0000);
        end
        u_host_driver_model.wr(OFS_ACCEPT_PAGE, 4'hF, 32'h0000_0001);
        u_host_driver_model.wr(OFS_ACCEPT_WORD, 4'hF, 32'hFFFF_FFFF);
        rchk(OFS_ACCEPT_WORD, OFFERED_FEATURES[63:32]);
        $display("test features done");
        u_host_driver_model.wr(OFS_RING_SIZE, 4'hF, 32'h0007_0040);
        u_host_driver_model.wr(OFS_ADDR_FIRST, 4'hF, 32'h1234_5678);
        u_host_driver_model.wr(OFS_ADDR_FIRST + 6'h04, 4'hF, 32'h9ABC_DEF0);
        sel(1);
        u_host_driver_model.wr(OFS_RING_SIZE, 4'h3, 32'h0000_0030);
        rchk(OFS_RING_SIZE, {16'h0000, MAX_RING_ENTRIES});
        rchk(OFS_ADDR_FIRST, 32'h0000_0000);
        rchk(OFS_RING_RUN, 32'h0001_0000);
        rchk(OFS_TAG_RESET, 32'h0000_0001);
        rchk(OFS_MGMT, {MGMT_COUNT, MGMT_FIRST});
        sel(3);
        rchk(OFS_RING_SIZE, 32'h0000_0000);
        sel(0);
        rchk(OFS_RING_SIZE, 32'h0007_0040);
        rchk(OFS_ADDR_FIRST + 6'h04, 32'h9ABC_DEF0);
        $display("test per ring fields done");
        u_host_driver_model.wr(OFS_RING_RUN, 4'h3, 32'h0000_0001);
        #1 chk_pin(ring_run, 3'b001);
        rchk(OFS_TAG_RESET, 32'h0000_0000);
        u_host_driver_model.wr(OFS_TAG_RESET, 4'hC, 32'h0001_0000);
        rchk(OFS_TAG_RESET, 32'h0001_0000);
        repeat (RING_RESET_CYCLES) @(posedge clock);
        rchk(OFS_TAG_RESET, 32'h0000_0000);
        rchk(OFS_RING_RUN, 32'h0000_0000);
        rchk(OFS_RING_SIZE, {16'h0000, MAX_RING_ENTRIES});
        $display("test ring reset done");
        devcfg_pulse(1'b1);
        rchk(OFS_STATUS, 32'h0000_0100);
        devcfg_pulse(1'b0);
        rchk(OFS_STATUS, 32'h0000_0200);
        devcfg_pulse(1'b0);
        rchk(OFS_STATUS, 32'h0000_0200);
        $display("test change counter done");
        u_host_driver_model.wr(OFS_STATUS, 4'h1, 32'h0000_000B);
        rchk(OFS_STATUS, 32'h0000_020B);
        chk_pin({2'b00, features_locked}, 3'b001);
        u_host_driver_model.wr(OFS_MGMT, 4'hF, 32'h0000_0000);
        rchk(OFS_MGMT, {MGMT_COUNT, MGMT_FIRST});
        u_host_driver_model.wr(OFS_RING_RUN, 4'h3, 32'h0000_0001);
        #1 chk_pin(ring_run, 3'b001);
        u_host_driver_model.wr(OFS_STATUS, 4'h1, 32'h0000_0000);
        #1 chk_pin({2'b00, dev_reset_busy}, 3'b001);
        rchk(OFS_STATUS, 32'h0000_020B);
        chk_pin(ring_run, 3'b000);
        repeat (DEV_RESET_CYCLES + 1) @(posedge clock);
        rchk(OFS_STATUS, 32'h0000_0200);
        u_host_driver_model.wr(OFS_ACCEPT_PAGE, 4'hF, 32'h0000_0001);
        rchk(OFS_ACCEPT_WORD, 32'h0000_0000);
        $display("test device reset done");
        test_done();
    end
endmodule
